// >>> hdl/spiq_pkg.sv
`default_nettype none
package spiq_pkg;
    localparam int unsigned SPIQ_BITS        = 8;
    // master serial clock half period in core cycles (4 -> 25 MHz)
    localparam int unsigned SPIQ_HALF_CYCLES = 4;
    // sample index of the bit 1 capture strobe (7th sample)
    localparam logic [2:0]  SPIQ_BIT1_SAMPLE = 3'h6;
    localparam logic [2:0]  SPIQ_LAST_SAMPLE = 3'h7;
    // reset values
    localparam logic        SPIQ_TX_EMPTY_RST = 1'h1;
    localparam logic [7:0]  SPIQ_DATA_RST     = 8'h00;

    typedef enum logic [0:0] {
        SPIQ_IDLE = 1'b0,
        SPIQ_RUN  = 1'b1
    } spiq_state_t;
endpackage
`default_nettype wire

// >>> hdl/spiq_sync.sv
`default_nettype none
module spiq_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule // spiq_sync
`default_nettype wire

// >>> hdl/spiq_core.sv
`default_nettype none
module spiq_core #(
    parameter int unsigned HALF_CYCLES = spiq_pkg::SPIQ_HALF_CYCLES
) (
    // clocks and reset
    input  wire logic       core_clk_i,
    input  wire logic       link_sck_i,
    input  wire logic       rstn_i,
    // cpu strobes, one cycle each
    input  wire logic       wr_data_i,
    input  wire logic [7:0] wr_byte_i,
    input  wire logic       wr_control_i,
    input  wire logic       rd_status_i,
    input  wire logic       rd_data_i,
    // control values taken on wr_control_i
    input  wire logic       module_enable_i,
    input  wire logic       master_select_i,
    input  wire logic       clock_phase_i,
    input  wire logic       clock_polarity_i,
    input  wire logic       mode_fault_enable_i,
    input  wire logic       error_irq_enable_i,
    input  wire logic       rx_irq_enable_i,
    // control and status
    output logic            module_enable_o,
    output logic            master_select_o,
    output logic            tx_empty_flag_o,
    output logic            rx_full_flag_o,
    output logic            overflow_flag_o,
    output logic            mode_fault_flag_o,
    output logic [7:0]      rx_data_o,
    output logic            rx_err_irq_o,
    // serial pins
    input  wire logic       ss_n_i,
    input  wire logic       mosi_i,
    input  wire logic       miso_i,
    output logic            sck_o,
    output logic            sck_oe_o,
    output logic            mosi_o,
    output logic            mosi_oe_o,
    output logic            miso_o,
    output logic            miso_oe_o
);
    localparam int unsigned HW = $clog2(HALF_CYCLES + 1);

    logic                   clock_phase;
    logic                   clock_polarity;
    logic                   mode_fault_enable;
    logic                   error_irq_enable;
    logic                   rx_irq_enable;
    logic [7:0]             tx_buf;
    logic [7:0]             tx_shift;
    logic [7:0]             m_rx_sh;
    spiq_pkg::spiq_state_t  m_state;
    logic [HW-1:0]          m_div;
    logic [3:0]             m_phase;
    logic                   arm_rx;
    logic                   arm_ovf;
    logic                   arm_mf;
    logic                   slave_go;
    logic                   s_active;
    logic                   s_done_pend;
    logic                   ss_n_d;
    logic                   done_tgl_d;
    logic                   bit1_tgl_d;
    // link domain
    logic                   link_rst_n;
    logic [2:0]             l_cnt;
    logic [7:0]             l_sh;
    logic [7:0]             l_word;
    logic                   l_done_tgl;
    logic                   l_bit1_tgl;
    // synchronised pins and events
    logic [4:0]             sync_q;
    logic                   ss_n_s;
    logic                   sck_s;
    logic                   miso_s;
    logic                   done_tgl_s;
    logic                   bit1_tgl_s;

    spiq_sync #(
        .WIDTH (5)
    ) u_sync (
        .clk_i  (core_clk_i),
        .rstn_i (rstn_i),
        .d_i    ({ss_n_i, link_sck_i, miso_i, l_done_tgl, l_bit1_tgl}),
        .q_o    (sync_q)
    );
    assign {ss_n_s, sck_s, miso_s, done_tgl_s, bit1_tgl_s} = sync_q;

    // decoded events
    logic is_master;
    logic is_slave;
    logic m_tick;
    logic m_sample;
    logic m_drive;
    logic m_last;
    logic m_fault;
    logic s_fault;
    logic s_start;
    logic s_done;
    logic s_bit1;
    logic m_bit1;
    logic tx_load;
    logic rx_done;
    logic [7:0] rx_word;

    assign is_master = module_enable_o && master_select_o;
    assign is_slave  = module_enable_o && !master_select_o;
    assign m_tick    = (m_state == spiq_pkg::SPIQ_RUN) && (m_div == HW'(HALF_CYCLES - 1));
    assign m_sample  = m_tick && (m_phase[0] == clock_phase);
    assign m_drive   = m_tick && (m_phase[0] != clock_phase);
    assign m_last    = m_tick && (m_phase == 4'hF);
    assign m_bit1    = m_sample && (m_phase[3:1] == spiq_pkg::SPIQ_BIT1_SAMPLE);
    // master sees select low: contention with another master
    assign m_fault   = is_master && mode_fault_enable && !ss_n_s;
    // slave deselected while a transfer runs
    assign s_fault   = is_slave && mode_fault_enable && s_active
                       && ss_n_s && !ss_n_d;
    assign s_start   = is_slave && !s_active && !ss_n_s
                       && (clock_phase ? (sck_s != clock_polarity)
                                       : ss_n_d);
    assign s_done    = s_done_pend && (sck_s == clock_polarity);
    assign s_bit1    = is_slave && (bit1_tgl_s != bit1_tgl_d);
    // a full buffer loads whenever the end is idle; slave waits out a transfer
    assign tx_load   = !tx_empty_flag_o
                       && ((is_master && m_state == spiq_pkg::SPIQ_IDLE)
                           || (is_slave && !s_active && !s_start));
    assign rx_done   = m_last || (is_slave && (done_tgl_s != done_tgl_d));
    // phase 0 took its eighth sample already; phase 1 samples on the last tick
    assign rx_word   = !m_last ? l_word
                       : (clock_phase ? {m_rx_sh[6:0], miso_s} : m_rx_sh);

    // control register, fault clears module enable only in master mode
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            module_enable_o   <= 1'b0;
            master_select_o   <= 1'b0;
            clock_phase       <= 1'b0;
            clock_polarity    <= 1'b0;
            mode_fault_enable <= 1'b0;
            error_irq_enable  <= 1'b0;
            rx_irq_enable     <= 1'b0;
        end else begin
            if (wr_control_i) begin
                module_enable_o   <= module_enable_i;
                master_select_o   <= master_select_i;
                clock_phase       <= clock_phase_i;
                clock_polarity    <= clock_polarity_i;
                mode_fault_enable <= mode_fault_enable_i;
                error_irq_enable  <= error_irq_enable_i;
                rx_irq_enable     <= rx_irq_enable_i;
            end
            if (m_fault) begin
                module_enable_o <= 1'b0;
            end
        end
    end

    // transmit buffer and its empty flag
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_buf          <= spiq_pkg::SPIQ_DATA_RST;
            tx_shift        <= spiq_pkg::SPIQ_DATA_RST;
            tx_empty_flag_o <= spiq_pkg::SPIQ_TX_EMPTY_RST;
        end else begin
            if (!module_enable_o || m_fault) begin
                tx_empty_flag_o <= 1'b1;
                tx_shift        <= spiq_pkg::SPIQ_DATA_RST;
            end else if (tx_load) begin
                tx_shift        <= tx_buf;
                tx_empty_flag_o <= 1'b1;
            end
            // a write while full is still taken; software must wait for empty
            if (wr_data_i) begin
                tx_buf          <= wr_byte_i;
                tx_empty_flag_o <= 1'b0;
            end
        end
    end

    // master engine: shifter is never shifted, so a slave frame without
    // a new write resends the same byte
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            m_state <= spiq_pkg::SPIQ_IDLE;
            m_div   <= '0;
            m_phase <= 4'h0;
            m_rx_sh <= spiq_pkg::SPIQ_DATA_RST;
        end else begin
            case (m_state)
                spiq_pkg::SPIQ_IDLE: begin
                    m_div   <= '0;
                    m_phase <= 4'h0;
                    if (tx_load && is_master) begin
                        m_state <= spiq_pkg::SPIQ_RUN;
                    end
                end
                spiq_pkg::SPIQ_RUN: begin
                    m_div <= m_tick ? '0 : m_div + HW'(1);
                    if (m_tick) begin
                        m_phase <= m_phase + 4'h1;
                    end
                    if (m_sample) begin
                        m_rx_sh <= {m_rx_sh[6:0], miso_s};
                    end
                    if (m_last) begin
                        m_state <= spiq_pkg::SPIQ_IDLE;
                    end
                end
                default: begin
                    m_state <= spiq_pkg::SPIQ_IDLE;
                end
            endcase
            if (!is_master || m_fault) begin
                m_state <= spiq_pkg::SPIQ_IDLE;
                m_div   <= '0;
                m_phase <= 4'h0;
            end
        end
    end

    // serial pin drive, released to port control when disabled
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sck_o     <= 1'b0;
            sck_oe_o  <= 1'b0;
            mosi_o    <= 1'b0;
            mosi_oe_o <= 1'b0;
            miso_oe_o <= 1'b0;
        end else begin
            sck_oe_o  <= is_master && !m_fault;
            mosi_oe_o <= is_master && !m_fault;
            miso_oe_o <= is_slave && !ss_n_s;
            if (m_state == spiq_pkg::SPIQ_IDLE) begin
                sck_o <= clock_polarity;
                if (clock_phase == 1'b0) begin
                    mosi_o <= tx_load ? tx_buf[7] : tx_shift[7];
                end
            end else if (m_tick) begin
                sck_o <= !sck_o;
            end
            if (m_drive) begin
                mosi_o <= tx_shift[3'h7 - 3'(m_phase[3:1] + {2'h0, !clock_phase})];
            end
        end
    end

    // slave transfer tracking from synchronised pins
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ss_n_d      <= 1'b1;
            done_tgl_d  <= 1'b0;
            bit1_tgl_d  <= 1'b0;
            slave_go    <= 1'b0;
            s_active    <= 1'b0;
            s_done_pend <= 1'b0;
        end else begin
            ss_n_d     <= ss_n_s;
            done_tgl_d <= done_tgl_s;
            bit1_tgl_d <= bit1_tgl_s;
            slave_go   <= is_slave;
            if (!is_slave || ss_n_s) begin
                s_active    <= 1'b0;
                s_done_pend <= 1'b0;
            end else if (s_start) begin
                s_active <= 1'b1;
            end else if (s_done) begin
                s_active    <= 1'b0;
                s_done_pend <= 1'b0;
            end else if (done_tgl_s != done_tgl_d) begin
                s_done_pend <= 1'b1;
            end
        end
    end

    // receive register, full and overflow flags; set wins over clear
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_data_o       <= spiq_pkg::SPIQ_DATA_RST;
            rx_full_flag_o  <= 1'b0;
            overflow_flag_o <= 1'b0;
            arm_rx          <= 1'b0;
            arm_ovf         <= 1'b0;
        end else begin
            if (rd_status_i) begin
                arm_rx  <= rx_full_flag_o;
                arm_ovf <= overflow_flag_o;
            end
            if (rd_data_i) begin
                arm_rx  <= 1'b0;
                arm_ovf <= 1'b0;
                if (arm_rx) begin
                    rx_full_flag_o <= 1'b0;
                end
                if (arm_ovf) begin
                    overflow_flag_o <= 1'b0;
                end
            end
            if ((m_bit1 || s_bit1) && rx_full_flag_o) begin
                overflow_flag_o <= 1'b1;
            end
            if (rx_done && !overflow_flag_o) begin
                rx_data_o      <= rx_word;
                rx_full_flag_o <= 1'b1;
            end
        end
    end

    // mode fault flag; any fault between status read and control write disarms
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_fault_flag_o <= 1'b0;
            arm_mf            <= 1'b0;
        end else begin
            if (rd_status_i) begin
                arm_mf <= mode_fault_flag_o;
            end else if (wr_control_i) begin
                arm_mf <= 1'b0;
            end
            if (m_fault || s_fault) begin
                mode_fault_flag_o <= 1'b1;
                arm_mf            <= 1'b0;
            end else if (wr_control_i && arm_mf) begin
                mode_fault_flag_o <= 1'b0;
            end
        end
    end

    // shared receive and error request
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_err_irq_o <= 1'b0;
        end else begin
            rx_err_irq_o <= (rx_irq_enable && rx_full_flag_o)
                            || (error_irq_enable
                                && (overflow_flag_o || mode_fault_flag_o));
        end
    end

    // link side: slave bit counter, held in reset while deselected so that
    // clock edges outside a selection are ignored
    assign link_rst_n = rstn_i && !ss_n_i && slave_go;

    always_ff @(posedge link_sck_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            l_cnt <= 3'h0;
            l_sh  <= 8'h00;
        end else begin
            l_cnt <= l_cnt + 3'h1;
            l_sh  <= {l_sh[6:0], mosi_i};
        end
    end

    // events stay on system reset only, so a deselect never makes a false edge
    always_ff @(posedge link_sck_i or negedge rstn_i) begin
        if (!rstn_i) begin
            l_word     <= 8'h00;
            l_done_tgl <= 1'b0;
            l_bit1_tgl <= 1'b0;
        end else if (link_rst_n) begin
            if (l_cnt == spiq_pkg::SPIQ_BIT1_SAMPLE) begin
                l_bit1_tgl <= !l_bit1_tgl;
            end
            if (l_cnt == spiq_pkg::SPIQ_LAST_SAMPLE) begin
                l_word     <= {l_sh[6:0], mosi_i};
                l_done_tgl <= !l_done_tgl;
            end
        end
    end

    // slave output bit picked from the stable shifter; the MSB must be
    // ready before the first edge, so this one output is not a flop
    assign miso_o = tx_shift[3'h7 - l_cnt];
endmodule // spiq_core
`default_nettype wire

// >>> testbench/spiq_monitor.sv
`default_nettype none
module spiq_monitor #(
    parameter int unsigned HALF_CYCLES = 4
) (
    // clock and reset
    input wire logic       core_clk_i,
    input wire logic       rstn_i,
    // cpu side and select pin
    input wire logic       wr_data_i,
    input wire logic       wr_control_i,
    input wire logic       rd_status_i,
    input wire logic       rd_data_i,
    input wire logic       mode_fault_enable_i,
    input wire logic       ss_n_i,
    // design outputs
    input wire logic       module_enable_o,
    input wire logic       master_select_o,
    input wire logic       tx_empty_flag_o,
    input wire logic       rx_full_flag_o,
    input wire logic       overflow_flag_o,
    input wire logic       mode_fault_flag_o,
    input wire logic [7:0] rx_data_o,
    input wire logic       sck_oe_o,
    input wire logic       mosi_oe_o,
    input wire logic       miso_oe_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // one whole master byte plus load slack
    localparam int EMPTY_MAX = 20 * HALF_CYCLES + 8;

    logic rx_arm;
    logic ov_arm;
    logic mf_arm;
    logic mfe_q;

    // armed by a status read that saw the flag
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_arm <= 1'b0;
            ov_arm <= 1'b0;
            mf_arm <= 1'b0;
            mfe_q  <= 1'b0;
        end else begin
            rx_arm <= (rd_status_i && rx_full_flag_o) || (rx_arm && !rd_data_i);
            ov_arm <= (rd_status_i && overflow_flag_o) || (ov_arm && !rd_data_i);
            mf_arm <= (rd_status_i && mode_fault_flag_o) || (mf_arm && !wr_control_i);
            mfe_q  <= wr_control_i ? mode_fault_enable_i : mfe_q;
        end
    end

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    // select history guards against a master fault landing in the same cycle
    a_write_clears_empty: assert property (
        wr_data_i && tx_empty_flag_o && module_enable_o && !wr_control_i && ss_n_i
        && $past(ss_n_i) && $past(ss_n_i, 2) |=> !tx_empty_flag_o)
        else $error("empty flag not cleared by write");
    a_empty_returns: assert property (
        $fell(tx_empty_flag_o) && master_select_o |-> ##[1:EMPTY_MAX] tx_empty_flag_o)
        else $error("queued byte never moved to shifter");
    a_rx_full_clears: assert property (
        rd_data_i && rx_arm && !overflow_flag_o |=> !rx_full_flag_o)
        else $error("full flag not cleared");
    a_ovf_clears: assert property (
        rd_data_i && ov_arm |=> !overflow_flag_o)
        else $error("overflow flag not cleared");
    a_ovf_holds_data: assert property (
        overflow_flag_o && !rd_data_i |=> $stable(rx_data_o) && rx_full_flag_o)
        else $error("receive data changed during overflow");
    a_fault_sticky: assert property (
        mode_fault_flag_o && !mf_arm |=> mode_fault_flag_o)
        else $error("fault flag cleared without status read");
    a_fault_needs_en: assert property (
        $rose(mode_fault_flag_o) |-> mfe_q)
        else $error("fault flag set while disabled");
    a_master_fault: assert property (
        $rose(mode_fault_flag_o) && master_select_o |-> !module_enable_o
        && tx_empty_flag_o && !sck_oe_o && !mosi_oe_o && $stable(master_select_o))
        else $error("master fault side effects wrong");
    a_slave_fault_keeps: assert property (
        $rose(mode_fault_flag_o) && !master_select_o && $past(module_enable_o)
        |-> module_enable_o)
        else $error("slave fault disabled the module");
    a_miso_released: assert property (
        ss_n_i && $past(ss_n_i) && $past(ss_n_i, 2) && $past(ss_n_i, 3) |-> !miso_oe_o)
        else $error("deselected slave drives miso");
    a_slave_pins_in: assert property (
        !master_select_o && $past(!master_select_o) |-> !sck_oe_o && !mosi_oe_o)
        else $error("slave drives clock or mosi");

    c_overflow: cover property ($rose(overflow_flag_o));
    c_master_fault: cover property ($rose(mode_fault_flag_o) && master_select_o);
    c_slave_byte: cover property ($rose(rx_full_flag_o) && !master_select_o);
endmodule // spiq_monitor
`default_nettype wire

// >>> testbench/spiq_far_end.sv
`default_nettype none
module spiq_far_end (
    // design side of the wires
    input  wire logic sck_i,
    input  wire logic miso_i,
    input  wire logic mosi_i,
    // driven wires
    output logic      miso_o,
    output logic      link_sck_o,
    output logic      mosi_o,
    output logic      ss_n_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [15:0] sh = 16'hFFFF;
    // bits the design sent as master, taken on the leading clock edge
    logic [7:0]  mrx = 8'h00;

    always @(posedge sck_i) mrx <= {mrx[6:0], mosi_i};

    assign miso_o = sh[15];
    initial begin
        link_sck_o = 1'b0;
        mosi_o = 1'b0;
        ss_n_o = 1'b1;
    end
    // remote slave, mode 0 only: shifts on the trailing clock edge
    always @(negedge sck_i) sh <= {sh[14:0], ~sh[0]};

    task automatic load(input logic [15:0] v);
        sh = v;
    endtask

    // remote master frame; nb below 8 aborts, nb 0 is a bare select pulse
    task automatic frame(input logic [7:0] b, input int nb, output logic [7:0] got);
        got = 8'h00;
        ss_n_o = 1'b0;
        #30;
        for (int i = 0; i < nb; i++) begin
            mosi_o = b[7-i];
            #5 got = {got[6:0], miso_i};
            #1 link_sck_o = 1'b1;
            #6 link_sck_o = 1'b0;
        end
        #40 ss_n_o = 1'b1;
        mosi_o = ~mosi_o;
        #40;
    endtask
endmodule // spiq_far_end
`default_nettype wire

// >>> testbench/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic       core_clk_i = 1'b0;
    logic       rstn_i = 1'b0;
    logic       wr_data_i = 1'b0, wr_control_i = 1'b0, rd_status_i = 1'b0, rd_data_i = 1'b0;
    logic [7:0] wr_byte_i = 8'h00;
    logic       module_enable_i = 1'b0, master_select_i = 1'b0, clock_phase_i = 1'b0;
    logic       clock_polarity_i = 1'b0, mode_fault_enable_i = 1'b0;
    logic       error_irq_enable_i = 1'b0, rx_irq_enable_i = 1'b0;
    logic       link_sck_i, ss_n_i, mosi_i, miso_i;
    logic       module_enable_o, master_select_o, tx_empty_flag_o, rx_full_flag_o;
    logic       overflow_flag_o, mode_fault_flag_o, rx_err_irq_o;
    logic [7:0] rx_data_o;
    logic       sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
    int         n_errors = 0;
    int         samples_checked = 0;
    // pull-down on the clock line, floating miso when released
    wire logic  sck_line = sck_oe_o & sck_o;
    wire logic  miso_line = miso_oe_o ? miso_o : 1'bz;

    always #2.5 core_clk_i = ~core_clk_i;

    spiq_core #(.HALF_CYCLES(4)) spiq_core_inst (
        .core_clk_i, .link_sck_i, .rstn_i, .wr_data_i, .wr_byte_i, .wr_control_i,
        .rd_status_i, .rd_data_i, .module_enable_i, .master_select_i, .clock_phase_i,
        .clock_polarity_i, .mode_fault_enable_i, .error_irq_enable_i, .rx_irq_enable_i,
        .module_enable_o, .master_select_o, .tx_empty_flag_o, .rx_full_flag_o,
        .overflow_flag_o, .mode_fault_flag_o, .rx_data_o, .rx_err_irq_o, .ss_n_i, .mosi_i,
        .miso_i, .sck_o, .sck_oe_o, .mosi_o, .mosi_oe_o, .miso_o, .miso_oe_o
    );

    spiq_far_end spiq_far_end_inst (
        .sck_i(sck_line), .miso_i(miso_line), .mosi_i(mosi_o), .miso_o(miso_i),
        .link_sck_o(link_sck_i), .mosi_o(mosi_i), .ss_n_o(ss_n_i)
    );

    // en ms empty full ovf fault irq sck_oe
    function automatic logic [7:0] st();
        return {module_enable_o, master_select_o, tx_empty_flag_o, rx_full_flag_o,
                overflow_flag_o, mode_fault_flag_o, rx_err_irq_o, sck_oe_o};
    endfunction

    function automatic logic [7:0] oe();
        return {5'h00, sck_oe_o, mosi_oe_o, miso_oe_o};
    endfunction

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    // strobes are one cycle wide with a gap, so no signal is set twice at once
    task automatic cpu(input logic [3:0] s, input logic [7:0] b);
        @(negedge core_clk_i);
        {wr_data_i, wr_control_i, rd_status_i, rd_data_i} = s;
        wr_byte_i = b;
        @(negedge core_clk_i);
        {wr_data_i, wr_control_i, rd_status_i, rd_data_i} = 4'h0;
    endtask

    task automatic ctl(input logic [6:0] v);
        {module_enable_i, master_select_i, clock_phase_i, clock_polarity_i,
         mode_fault_enable_i, error_irq_enable_i, rx_irq_enable_i} = v;
        cpu(4'h4, 8'h00);
    endtask

    task automatic wait_hi(input string n, ref logic s, input int lim);
        int k;
        k = 0;
        while (s !== 1'b1 && k < lim) begin
            @(negedge core_clk_i);
            k++;
        end
        chk(n, 8'h01, {7'h00, s});
    endtask

    task automatic mf(input logic e);
        repeat (2) @(negedge core_clk_i);
        chk("fault", {7'h00, e}, {7'h00, mode_fault_flag_o});
    endtask

    task automatic sframe(input logic [7:0] b, input logic [7:0] e);
        logic [7:0] g;
        spiq_far_end_inst.frame(b, 8, g);
        chk("miso", e, g);
        wait_hi("rx_full", rx_full_flag_o, 10);
        chk("rx_data", b, rx_data_o);
        cpu(4'h2, 8'h00);
        cpu(4'h1, 8'h00);
    endtask

    task automatic s_master;
        ctl(7'h66);
        spiq_far_end_inst.load(16'hC35A);
        repeat (2) @(negedge core_clk_i);
        chk("oe", 8'h06, oe());
        cpu(4'h8, 8'hA5);
        wait_hi("tx_empty", tx_empty_flag_o, 4);
        cpu(4'h8, 8'h3C);
        repeat (3) @(negedge core_clk_i);
        chk("tx_empty", 8'h00, {7'h00, tx_empty_flag_o});
        wait_hi("rx_full", rx_full_flag_o, 100);
        chk("rx_data", 8'hC3, rx_data_o);
        chk("mosi", 8'hA5, spiq_far_end_inst.mrx);
        wait_hi("tx_empty", tx_empty_flag_o, 6);
        wait_hi("overflow", overflow_flag_o, 100);
        repeat (40) @(negedge core_clk_i);
        chk("state", 8'hFB, st());
        chk("rx_data", 8'hC3, rx_data_o);
        chk("mosi", 8'h3C, spiq_far_end_inst.mrx);
        cpu(4'h1, 8'h00);
        chk("state", 8'hFB, st());
        cpu(4'h2, 8'h00);
        cpu(4'h1, 8'h00);
        cpu(4'h2, 8'h00);
        chk("state", 8'hE1, st());
    endtask

    task automatic s_mfault;
        logic [7:0] g;
        spiq_far_end_inst.frame(8'h00, 0, g);
        chk("state", 8'h66, st());
        ctl(7'h26);
        mf(1'b1);
        cpu(4'h2, 8'h00);
        ctl(7'h26);
        mf(1'b0);
        chk("state", 8'h60, st());
    endtask

    task automatic s_slave;
        ctl(7'h44);
        repeat (2) @(negedge core_clk_i);
        chk("oe", 8'h00, oe());
        cpu(4'h8, 8'h96);
        repeat (3) @(negedge core_clk_i);
        chk("tx_empty", 8'h01, {7'h00, tx_empty_flag_o});
        sframe(8'h69, 8'h96);
        sframe(8'h2D, 8'h96);
        fork
            sframe(8'hB4, 8'h96);
            begin
                #100;
                cpu(4'h8, 8'hE1);
                chk("tx_empty", 8'h00, {7'h00, tx_empty_flag_o});
            end
        join
        sframe(8'h4B, 8'hE1);
    endtask

    task automatic s_sfault;
        logic [7:0] g;
        spiq_far_end_inst.frame(8'hF0, 4, g);
        chk("state", 8'hA4, st());
        ctl(7'h40);
        mf(1'b1);
        cpu(4'h2, 8'h00);
        ctl(7'h40);
        mf(1'b0);
        spiq_far_end_inst.frame(8'h00, 0, g);
        mf(1'b0);
        ctl(7'h54);
        spiq_far_end_inst.frame(8'h00, 0, g);
        mf(1'b0);
        ctl(7'h44);
        spiq_far_end_inst.frame(8'h00, 0, g);
        mf(1'b1);
    endtask

    task automatic print_verdict;
        if (n_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (5) @(negedge core_clk_i);
        rstn_i = 1'b1;
        chk("state", 8'h20, st());
        chk("rx_data", 8'h00, rx_data_o);
        s_master();
        s_mfault();
        s_slave();
        s_sfault();
        print_verdict();
    end

    // whole run is several hundred cycles
    initial begin
        #100000;
        n_errors++;
        print_verdict();
    end
endmodule // tb_top

bind spiq_core spiq_monitor #(.HALF_CYCLES(HALF_CYCLES)) spiq_monitor_inst (
    .core_clk_i, .rstn_i, .wr_data_i, .wr_control_i, .rd_status_i, .rd_data_i,
    .mode_fault_enable_i, .ss_n_i, .module_enable_o, .master_select_o, .tx_empty_flag_o,
    .rx_full_flag_o, .overflow_flag_o, .mode_fault_flag_o, .rx_data_o, .sck_oe_o,
    .mosi_oe_o, .miso_oe_o
);
`default_nettype wire
